// [verilog/dmfc_pkg.sv]
// Purpose: constants, types and helpers for the mode register feature host
// Assumes: opcode on A13..A0, mode register select on BG0,BA1,BA0
// Notes:   MR field positions below are mode register bit numbers
// Behaviour
// - host zeroes every unused present address bit; the code only zeroes the address bits outside ADDR_USED
// - host sets write command latency when CRC+DM; the code only refuses an MR3 write whose latency field is zero
// - gear-down needs MRS then sync pulse
// - two-cycle write preamble needs CWL above minimum
// - read preamble selectable, with training mode
// - with CAL, command follows chip select later
// - DBI and data mask never enabled together
// - termination input held valid when buffer on
// - parity error flag sticky until MRS clear
// - CRC error flag sticky until MRS clear
// - parity covers ACT, A16..A0, BA, BG
// - host programs tCCD_L for operating frequency; the code only refuses an MR6 tCCD_L below the configured minimum
package dmfc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_CFG    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    // command register layout
    localparam int CMD_BA_LSB = 14;
    localparam int CMD_BG_LSB = 16;
    // configuration register layout
    localparam int CFG_CRC_EN   = 0;
    localparam int CFG_DM_EN    = 1;
    localparam int CFG_CWL_LSB  = 2;
    localparam int CFG_CCDL_LSB = 5;
    // status register layout
    localparam int ST_BUSY    = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_GEAR2N  = 2;
    localparam int ST_PAR_EN  = 3;
    localparam int ST_CAL_LSB = 4;
    // mode register numbers and field positions
    localparam logic [2:0] MR_RCW = 3'h7;
    localparam logic [2:0] MR2    = 3'h2;
    localparam logic [2:0] MR3    = 3'h3;
    localparam logic [2:0] MR4    = 3'h4;
    localparam logic [2:0] MR5    = 3'h5;
    localparam logic [2:0] MR6    = 3'h6;
    localparam int MR2_CWL_LSB  = 3;
    localparam int MR3_GEARDOWN = 3;
    localparam int MR3_WCL_LSB  = 9;
    localparam int MR4_CAL_LSB  = 6;
    localparam int MR4_WPRE2    = 12;
    localparam int MR5_PL_LSB   = 0;
    localparam int MR5_DM       = 10;
    localparam int MR5_WDBI     = 11;
    localparam int MR5_RDBI     = 12;
    localparam int MR6_CCDL_LSB = 10;
    // mode register set spacing in link clocks
    localparam logic [3:0] MRD_CK = 4'h8;

    typedef struct packed {
        logic        cs_n;
        logic        act_n;
        logic        ras_n;   // shares A16
        logic        cas_n;   // shares A15
        logic        we_n;    // shares A14
        logic [1:0]  bg;
        logic [1:0]  ba;
        logic [13:0] a;
        logic        par;
    } dmfc_ca_t;

    localparam dmfc_ca_t CA_DES = '{cs_n: 1'b1, act_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                    we_n: 1'b1, bg: 2'h0, ba: 2'h0, a: 14'h0000, par: 1'b0};

    typedef enum logic [2:0] {
        DMFC_IDLE = 3'b000,
        DMFC_CAL  = 3'b001,
        DMFC_CMD  = 3'b010,
        DMFC_GAP  = 3'b011,
        DMFC_SYNC = 3'b100
    } dmfc_state_t;

    // clocks between chip select and command for a CAL code
    function automatic logic [3:0] dmfc_cal_clocks(input logic [2:0] code);
        case (code)
            3'h1: dmfc_cal_clocks = 4'h3;
            3'h2: dmfc_cal_clocks = 4'h4;
            3'h3: dmfc_cal_clocks = 4'h5;
            3'h4: dmfc_cal_clocks = 4'h6;
            3'h5: dmfc_cal_clocks = 4'h8;
            default: dmfc_cal_clocks = 4'h0;
        endcase
    endfunction : dmfc_cal_clocks

    // even parity over the covered command and address lines
    function automatic logic dmfc_parity(input dmfc_ca_t c);
        dmfc_parity = ^{c.act_n, c.ras_n, c.cas_n, c.we_n, c.bg, c.ba, c.a};
    endfunction : dmfc_parity
endpackage : dmfc_pkg

// [verilog/dmfc_host.sv]
// Purpose: issues mode register set commands to a DDR4 device from APB
// Assumes: single rank, commands launched on falling link clock edges
// Notes:   the host makes the link clock by dividing sys_clk
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module dmfc_host #(
    parameter int          CK_HALF   = 4,         // sys_clk cycles per link clock half
    parameter logic [13:0] ADDR_USED = 14'h3FFF   // address pins present on the part
) (
    input  wire logic              sys_clk,   // 250 MHz system clock
    input  wire logic              rst_n,     // asynchronous reset, active low
    input  wire logic [7:0]        paddr,     // APB address
    input  wire logic              psel,      // APB select
    input  wire logic              penable,   // APB enable
    input  wire logic              pwrite,    // APB direction
    input  wire logic [31:0]       pwdata,    // APB write data
    output logic [31:0]            prdata,    // APB read data
    output logic                   pready,    // APB ready
    output logic                   pslverr,   // APB error
    output logic                   ck_t,      // link clock true
    output logic                   ck_c,      // link clock complement
    output logic                   cke,       // clock enable pin
    output logic                   odt,       // termination control pin
    output dmfc_pkg::dmfc_ca_t     ca         // command and address pins
);
    import dmfc_pkg::*;

    logic [7:0]  div_reg;
    logic        ck_reg;
    logic        ck_c_reg;
    logic        ck_fall;
    logic [17:0] cmd_reg;
    logic [7:0]  cfg_reg;
    logic        pend_reg;
    logic        refused_reg;
    logic        busy_reg;
    logic        gear_reg;
    logic        sync_due_reg;
    logic        hold2_reg;
    logic [2:0]  cwl_sh_reg;
    logic        wpre2_sh_reg;
    logic [2:0]  cal_sh_reg;
    logic [2:0]  pl_sh_reg;
    logic [3:0]  cnt_reg;
    dmfc_state_t state_reg;
    dmfc_ca_t    ca_reg;
    dmfc_ca_t    mrs_word;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    logic        pready_reg;
    logic        odt_reg;
    logic        cke_reg;
    logic        wr_cmd;
    logic        wr_cfg;
    logic        wr_status;
    logic        bad;
    logic        accept;
    logic [2:0]  mr_sel;
    logic [13:0] op_in;
    logic [3:0]  cal_clk;
    logic        done;

    // link clock divider, falling edge marks the launch point
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg  <= 8'h00;
            ck_reg   <= 1'b0;
            ck_c_reg <= 1'b1;
        end else if (div_reg == 8'(CK_HALF - 1)) begin
            div_reg  <= 8'h00;
            ck_reg   <= ~ck_reg;
            ck_c_reg <= ck_reg;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    assign ck_fall = ck_reg && (div_reg == 8'(CK_HALF - 1));
    assign ck_t    = ck_reg;
    assign ck_c    = ck_c_reg;

    // APB decode and command checks
    assign wr_cmd    = psel && penable && pwrite && (paddr == OFS_CMD);
    assign wr_cfg    = psel && penable && pwrite && (paddr == OFS_CFG);
    assign wr_status = psel && penable && pwrite && (paddr == OFS_STATUS);
    assign mr_sel    = {pwdata[CMD_BG_LSB], pwdata[CMD_BA_LSB+1], pwdata[CMD_BA_LSB]};
    assign op_in     = pwdata[13:0];
    always_comb begin
        bad = 1'b0;
        if (mr_sel == MR_RCW)
            bad = 1'b1;
        if (mr_sel == MR3 && cfg_reg[CFG_CRC_EN] && cfg_reg[CFG_DM_EN]
            && op_in[MR3_WCL_LSB+:2] == 2'h0)
            bad = 1'b1;
        if (mr_sel == MR2 && wpre2_sh_reg
            && op_in[MR2_CWL_LSB+:3] <= cfg_reg[CFG_CWL_LSB+:3])
            bad = 1'b1;
        if (mr_sel == MR4 && op_in[MR4_WPRE2]
            && cwl_sh_reg <= cfg_reg[CFG_CWL_LSB+:3])
            bad = 1'b1;
        if (mr_sel == MR5 && op_in[MR5_DM]
            && (op_in[MR5_WDBI] || op_in[MR5_RDBI]))
            bad = 1'b1;
        if (mr_sel == MR6 && op_in[MR6_CCDL_LSB+:3] < cfg_reg[CFG_CCDL_LSB+:3])
            bad = 1'b1;
    end
    assign accept = wr_cmd && !busy_reg && !bad;

    // command and configuration registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= 18'h00000;
            cfg_reg <= 8'h00;
        end else begin
            if (accept)
                cmd_reg <= {pwdata[17:14], op_in & ADDR_USED};
            if (wr_cfg)
                cfg_reg <= pwdata[7:0];
        end
    end

    // refused flag, a new refusal wins over the clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            refused_reg <= 1'b0;
        else if (wr_cmd && (busy_reg || bad))
            refused_reg <= 1'b1;
        else if (wr_status && pwdata[ST_REFUSED])
            refused_reg <= 1'b0;
    end

    // pending request, cleared once the command has left
    assign done = ck_fall && (state_reg == DMFC_CMD) && !hold2_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            pend_reg <= 1'b0;
        else if (accept)
            pend_reg <= 1'b1;
        else if (done)
            pend_reg <= 1'b0;
    end

    // busy covers the pending command and the trailing spacing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            busy_reg <= 1'b0;
        else
            busy_reg <= accept || pend_reg || (state_reg != DMFC_IDLE);
    end

    // APB answer, prepared during setup so it comes from flip-flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
            pready_reg  <= 1'b0;
        end else begin
            pready_reg <= 1'b1;
            if (psel && !penable) begin
                pslverr_reg <= 1'b0;
                case (paddr)
                    OFS_CMD:    prdata_reg <= {14'h0000, cmd_reg};
                    OFS_CFG:    prdata_reg <= {24'h000000, cfg_reg};
                    OFS_STATUS: prdata_reg <= {25'h0000000, cal_sh_reg, pl_sh_reg != 3'h0,
                                               gear_reg, refused_reg, busy_reg};
                    default: begin
                        prdata_reg  <= 32'h00000000;
                        pslverr_reg <= 1'b1;
                    end
                endcase
            end
        end
    end
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;
    assign pready  = pready_reg;

    // static pins: clock enabled, termination held at a valid low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cke_reg <= 1'b0;
            odt_reg <= 1'b0;
        end else begin
            cke_reg <= 1'b1;
            odt_reg <= 1'b0;
        end
    end
    assign cke = cke_reg;
    assign odt = odt_reg;

    // mode register set word with parity when enabled
    always_comb begin
        mrs_word       = CA_DES;
        mrs_word.cs_n  = 1'b0;
        mrs_word.ras_n = 1'b0;
        mrs_word.cas_n = 1'b0;
        mrs_word.we_n  = 1'b0;
        mrs_word.bg    = cmd_reg[17:16];
        mrs_word.ba    = cmd_reg[15:14];
        mrs_word.a     = cmd_reg[13:0];
        mrs_word.par   = (pl_sh_reg != 3'h0) ? dmfc_parity(mrs_word) : 1'b0;
    end
    assign cal_clk = dmfc_cal_clocks(cal_sh_reg);

    // command sequencer, moves on link clock falling edges
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= DMFC_IDLE;
            ca_reg    <= CA_DES;
            cnt_reg   <= 4'h0;
            hold2_reg <= 1'b0;
        end else if (ck_fall) begin
            case (state_reg)
                DMFC_IDLE: begin
                    hold2_reg <= gear_reg;
                    if (pend_reg && cal_clk != 4'h0) begin
                        ca_reg      <= CA_DES;
                        ca_reg.cs_n <= 1'b0;
                        cnt_reg     <= cal_clk - 4'h1;
                        state_reg   <= DMFC_CAL;
                    end else if (pend_reg) begin
                        ca_reg    <= mrs_word;
                        state_reg <= DMFC_CMD;
                    end
                end
                DMFC_CAL: begin
                    if (cnt_reg == 4'h0) begin
                        ca_reg      <= mrs_word;
                        ca_reg.cs_n <= 1'b1;
                        state_reg   <= DMFC_CMD;
                    end else begin
                        ca_reg  <= CA_DES;
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                DMFC_CMD: begin
                    if (hold2_reg) begin
                        hold2_reg <= 1'b0;
                    end else begin
                        ca_reg    <= CA_DES;
                        cnt_reg   <= MRD_CK - 4'h1;
                        state_reg <= DMFC_GAP;
                    end
                end
                DMFC_GAP: begin
                    ca_reg <= CA_DES;
                    if (cnt_reg != 4'h0) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else if (sync_due_reg) begin
                        ca_reg      <= CA_DES;
                        ca_reg.cs_n <= 1'b0;
                        state_reg   <= DMFC_SYNC;
                    end else begin
                        state_reg <= DMFC_IDLE;
                    end
                end
                DMFC_SYNC: begin
                    ca_reg    <= CA_DES;
                    cnt_reg   <= MRD_CK - 4'h1;
                    state_reg <= DMFC_GAP;
                end
                default: begin
                    ca_reg    <= CA_DES;
                    state_reg <= DMFC_IDLE;
                end
            endcase
        end
    end
    assign ca = ca_reg;

    // shadows of delivered settings; error clears in MR5 pass as written
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cwl_sh_reg   <= 3'h0;
            wpre2_sh_reg <= 1'b0;
            cal_sh_reg   <= 3'h0;
            pl_sh_reg    <= 3'h0;
        end else if (done) begin
            case ({cmd_reg[16], cmd_reg[15:14]})
                MR2: cwl_sh_reg <= cmd_reg[MR2_CWL_LSB+:3];
                MR4: begin
                    wpre2_sh_reg <= cmd_reg[MR4_WPRE2];
                    cal_sh_reg   <= cmd_reg[MR4_CAL_LSB+:3];
                end
                MR5: pl_sh_reg <= cmd_reg[MR5_PL_LSB+:3];
                default: pl_sh_reg <= pl_sh_reg;
            endcase
        end
    end

    // gear-down: after the enabling MRS a sync pulse switches to 2N
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gear_reg     <= 1'b0;
            sync_due_reg <= 1'b0;
        end else if (done && {cmd_reg[16], cmd_reg[15:14]} == MR3
                     && cmd_reg[MR3_GEARDOWN] && !gear_reg) begin
            sync_due_reg <= 1'b1;
        end else if (ck_fall && state_reg == DMFC_SYNC) begin
            sync_due_reg <= 1'b0;
            gear_reg     <= 1'b1;
        end
    end

    // checks on the pins and on refusals
    a_no_rcw_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !ca_reg.ras_n |-> {ca_reg.bg[0], ca_reg.ba} != MR_RCW)
        else $error("reserved register code issued");
    a_unused_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ca_reg.a & ~ADDR_USED) == 14'h0000)
        else $error("unused address bit driven high");
    a_parity_cover: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg == DMFC_CMD && pl_sh_reg != 3'h0) |-> ca_reg.par == dmfc_parity(ca_reg))
        else $error("parity does not cover command");
    a_parity_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (pl_sh_reg == 3'h0) |-> !ca_reg.par)
        else $error("parity driven while disabled");
    a_wcl_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_cmd && mr_sel == MR3 && cfg_reg[CFG_CRC_EN] && cfg_reg[CFG_DM_EN]
         && op_in[MR3_WCL_LSB+:2] == 2'h0) |=> refused_reg && !$rose(pend_reg))
        else $error("missing write command latency accepted");
    a_cwl_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_cmd && mr_sel == MR4 && op_in[MR4_WPRE2]
         && cwl_sh_reg <= cfg_reg[CFG_CWL_LSB+:3]) |=> refused_reg)
        else $error("two cycle preamble with low CWL accepted");
    a_dbi_dm_excl: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_cmd && mr_sel == MR5 && op_in[MR5_DM] && op_in[MR5_WDBI]) |=> refused_reg)
        else $error("DBI with data mask accepted");
    a_ccdl_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_cmd && mr_sel == MR6 && op_in[MR6_CCDL_LSB+:3] < cfg_reg[CFG_CCDL_LSB+:3])
        |=> refused_reg)
        else $error("short tCCD_L accepted");
    a_sync_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(gear_reg) |-> $past(state_reg) == DMFC_SYNC && ca_reg.cs_n)
        else $error("2N entered without sync pulse");
    a_cal_split: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg == DMFC_CMD && $past(state_reg) == DMFC_CAL) |-> ca_reg.cs_n)
        else $error("chip select low with delayed command");
    a_odt_valid: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 !odt_reg)
        else $error("termination pin not held low");
endmodule : dmfc_host

// [verif/dmfc_dev_model.sv]
// Purpose: behavioural DDR4 device seen at the command pins
// Assumes: commands sampled on rising ck_t, mode register decode only
// Notes:   no data path, so the crc flag only resets and clears
`timescale 1ns/10ps
module dmfc_dev_model (
    input  wire logic               ck_t,      // link clock
    input  wire logic               rst_n,     // device reset, active low
    input  wire dmfc_pkg::dmfc_ca_t ca,        // command and address pins
    output logic [7:0]              mrs_count, // mode sets taken
    output logic [2:0]              last_mr,   // last register written
    output logic [13:0]             last_op,   // last opcode written
    output logic                    par_err,   // parity error status
    output logic                    crc_err    // write crc error status
);
    import dmfc_pkg::*;
    logic [13:0] mr_q [0:7];
    logic [3:0]  cal_cnt;
    logic [3:0]  cal_n;
    logic [2:0]  sel;
    logic        take;
    logic        par_bad;
    // command decode, delayed by the programmed cs latency
    always_comb begin
        cal_n = (mr_q[4][8:6] == 3'h5) ? 4'h8 : {1'b0, mr_q[4][8:6]} + 4'h2;
        if (mr_q[4][8:6] == 3'h0) cal_n = 4'h0;
        sel = {ca.bg[0], ca.ba};
        take = (cal_n == 4'h0) ? !ca.cs_n : (cal_cnt == 4'h1);
        take = take && ca.act_n && !ca.ras_n && !ca.cas_n && !ca.we_n;
        par_bad = (mr_q[5][2:0] != 3'h0) && !(par_err && !mr_q[5][9]);
        par_bad = par_bad && (ca.par != ^{ca.act_n, ca.ras_n, ca.cas_n, ca.we_n,
                                          ca.bg, ca.ba, ca.a});
    end
    // counts clocks from chip select to the command
    always_ff @(posedge ck_t or negedge rst_n) begin
        if (!rst_n) cal_cnt <= 4'h0;
        else if (cal_cnt != 4'h0) cal_cnt <= cal_cnt - 4'h1;
        else if (!ca.cs_n) cal_cnt <= cal_n;
    end
    // mode register shadows and sticky error flags
    always_ff @(posedge ck_t or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) mr_q[i] <= 14'h0000;
            mrs_count <= 8'h00;
            last_mr   <= 3'h0;
            last_op   <= 14'h0000;
            par_err   <= 1'b0;
            crc_err   <= 1'b0;
        end else if (take && sel != MR_RCW) begin
            if (par_bad) begin
                par_err <= 1'b1;
            end else begin
                mrs_count <= mrs_count + 8'h01;
                last_mr   <= sel;
                last_op   <= ca.a;
                mr_q[sel] <= ca.a;
                if (sel == MR5) begin
                    par_err <= par_err & ca.a[4];
                    crc_err <= crc_err & ca.a[3];
                end
            end
        end
    end
endmodule : dmfc_dev_model

// [verif/testbench.sv]
// Purpose: self-checking bench for the mode register host
// Assumes: zero wait apb, link clock divided by four
// Notes:   row table first, then status, crc, gear-down and reset
`timescale 1ns/10ps
module testbench;
    import dmfc_pkg::*;
    typedef struct packed {
        logic [31:0] cmd;
        logic        refused;
        logic [13:0] op;
    } dmfc_row_t;
    logic        sys_clk = 1'b0;
    logic        rst_n, psel, penable, pwrite, pready, pslverr, ck_t, ck_c, cke, odt;
    logic [7:0]  paddr, mrs_count, cnt0;
    logic [31:0] pwdata, prdata, rd_q;
    logic        er_q, par_err, crc_err;
    logic [2:0]  last_mr;
    logic [13:0] last_op;
    dmfc_ca_t    ca;
    int          fail_count = 0;
    int          n_compared = 0;
    // command word, refused, opcode seen by the device
    dmfc_row_t rows [14] = '{
        '{32'h0000C200, 1'b0, 14'h0200}, '{32'h0001C000, 1'b1, 14'h0000},
        '{32'h00014C00, 1'b1, 14'h0000}, '{32'h00014400, 1'b0, 14'h0400},
        '{32'h00018400, 1'b1, 14'h0000}, '{32'h0001A800, 1'b0, 14'h0800},
        '{32'h00011000, 1'b1, 14'h0000},
        '{32'h00008010, 1'b0, 14'h0010}, '{32'h00011000, 1'b0, 14'h1000},
        '{32'h00008008, 1'b1, 14'h0000}, '{32'h00014001, 1'b0, 14'h0001},
        '{32'h00011040, 1'b0, 14'h1040}, '{32'h00018800, 1'b0, 14'h0800},
        '{32'h00011000, 1'b0, 14'h1000}};

    dmfc_host #(.CK_HALF(2), .ADDR_USED(14'h1FFF)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .odt(odt), .ca(ca));
    dmfc_dev_model dev_u (
        .ck_t(ck_t), .rst_n(rst_n), .ca(ca), .mrs_count(mrs_count), .last_mr(last_mr),
        .last_op(last_op), .par_err(par_err), .crc_err(crc_err));

    // 250 MHz system clock
    always #2 sys_clk = ~sys_clk;

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    task automatic check_bit(input string name, input logic exp, input logic got);
        check_val(name, {31'h0, exp}, {31'h0, got});
    endtask : check_bit

    // one apb transfer, held until pready is sampled high
    task automatic apb_xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        int k;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= ad;
        pwrite  <= wr;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) fail_count++;
        rd_q = prdata;
        er_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    // polls status until the command has left the pins
    task automatic wait_idle;
        int k;
        k = 0;
        do begin
            apb_xfer(1'b0, OFS_STATUS, 32'h0);
            k++;
        end while (rd_q[ST_BUSY] !== 1'b0 && k < 200);
        if (k >= 200) fail_count++;
    endtask : wait_idle

    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report

    // watchdog against a hung handshake
    initial begin
        #200000;
        fail_count++;
        final_report();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb_xfer(1'b1, OFS_CFG, 32'h44);
        foreach (rows[i]) begin
            cnt0 = mrs_count;
            apb_xfer(1'b1, OFS_CMD, rows[i].cmd);
            wait_idle();
            check_bit("refused", rows[i].refused, rd_q[ST_REFUSED]);
            check_val("count", {24'h0, cnt0 + {7'h0, !rows[i].refused}}, {24'h0, mrs_count});
            if (rows[i].refused) begin
                apb_xfer(1'b1, OFS_STATUS, 32'h2);
            end else begin
                check_val("mr", {29'h0, rows[i].cmd[16:14]}, {29'h0, last_mr});
                check_val("op", {18'h0, rows[i].op}, {18'h0, last_op});
            end
            $display("row %0d done", i);
        end
        check_bit("parity flag", 1'b0, par_err);
        check_bit("odt level", 1'b0, odt);
        check_bit("ck pair", ~ck_t, ck_c);
        apb_xfer(1'b0, OFS_STATUS, 32'h0);
        check_val("status", 32'h8, rd_q);
        apb_xfer(1'b0, 8'h0C, 32'h0);
        check_bit("slverr", 1'b1, er_q);
        check_val("unmapped", 32'h0, rd_q);
        $display("status test done");
        apb_xfer(1'b1, OFS_CFG, 32'h47);
        apb_xfer(1'b1, OFS_CMD, 32'hC000);
        wait_idle();
        check_bit("crc latency missing", 1'b1, rd_q[ST_REFUSED]);
        apb_xfer(1'b1, OFS_STATUS, 32'h2);
        apb_xfer(1'b1, OFS_CMD, 32'hC200);
        wait_idle();
        check_bit("crc latency set", 1'b0, rd_q[ST_REFUSED]);
        $display("crc test done");
        apb_xfer(1'b1, OFS_CFG, 32'h44);
        apb_xfer(1'b1, OFS_CMD, 32'hC008);
        wait_idle();
        check_bit("gear 2N", 1'b1, rd_q[ST_GEAR2N]);
        check_val("gear op", 32'h8, {18'h0, last_op});
        $display("gear test done");
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check_bit("cke in reset", 1'b0, cke);
        check_val("ca in reset", {6'h0, CA_DES}, {6'h0, ca});
        check_bit("flag in reset", 1'b0, par_err);
        check_bit("crc flag in reset", 1'b0, crc_err);
        check_bit("pready in reset", 1'b0, pready);
        check_bit("ck_c in reset", 1'b1, ck_c);
        rst_n <= 1'b1;
        apb_xfer(1'b0, OFS_STATUS, 32'h0);
        check_val("status after reset", 32'h0, rd_q);
        $display("reset test done");
        final_report();
    end
endmodule : testbench
